// file: eoc_consts.vh
// eoc_consts.vh: offsets, field positions, reset values and encodings
// for the equalizer output control block.
// assumes: included by bare name from each design file of the block.
`ifndef EOC_CONSTS_VH
`define EOC_CONSTS_VH

// register offsets, byte address on the register port
`define EOC_ADDR_MUTE_THR      8'h03
`define EOC_ADDR_CABLE_LEN     8'h25
`define EOC_ADDR_FIRST_OUTPUT_SWING    8'h30
`define EOC_ADDR_FIRST_OUTPUT_EMPH     8'h31
`define EOC_ADDR_SECOND_OUTPUT_SWING    8'h32
`define EOC_ADDR_SECOND_OUTPUT_EMPH     8'h33
`define EOC_ADDR_PATH_CTRL     8'h34

// per-output swing register
`define EOC_SWING_OVR_BIT      5
// per-output emphasis register
`define EOC_EMPH_OVR_BIT       6
// code field of both, bits 2..0
`define EOC_CODE_MSB           2
`define EOC_CODE_W             3

// length fields, bits 5..0
`define EOC_LEN_MSB            5
`define EOC_LEN_W              6
`define EOC_LEN_MAX            6'h37

// path control register fields
`define EOC_PATH_OVR_BIT       0
`define EOC_PATH_DUAL_BIT      1
`define EOC_FUNC_OVR_BIT       2
`define EOC_FUNC_BYPASS_BIT    3
`define EOC_SPLIT_EN_BIT       4

// reset values
`define EOC_RST_MUTE_THR       6'h37
`define EOC_RST_CODE           3'h0
`define EOC_RST_PATH_CTRL      5'h00

// four-level strap encoding
`define EOC_LVL_L              2'h0
`define EOC_LVL_R              2'h1
`define EOC_LVL_F              2'h2
`define EOC_LVL_H              2'h3

// strap level to swing / emphasis code
`define EOC_CODE_FOR_H         3'h0
`define EOC_CODE_FOR_F         3'h2
`define EOC_CODE_FOR_R         3'h3
`define EOC_CODE_FOR_L         3'h5

`endif

// file: eoc_strap_decode.v
// eoc_strap_decode.v: four-level strap decoder, one per strap pin.
// assumes: cmp_above comes from three comparators on the strap voltage,
// bit 0 at the low/resistor-low threshold, bit 2 at the float/high one.
`timescale 1ns/10ps
`include "eoc_consts.vh"

module eoc_strap_decode (
  input  wire       clk,
  input  wire       rst_b,
  input  wire [2:0] cmp_above,
  output reg  [1:0] level_q
);

  reg [1:0] level_d;

  // highest threshold crossed wins, so a broken thermometer still decodes
  always @* begin
    if (cmp_above[2]) begin
      level_d = `EOC_LVL_H;
    end else if (cmp_above[1]) begin
      level_d = `EOC_LVL_F;
    end else if (cmp_above[0]) begin
      level_d = `EOC_LVL_R;
    end else begin
      level_d = `EOC_LVL_L;
    end
  end

  // float level is the reset view: an open pin idles there
  always @(posedge clk) begin
    if (!rst_b) begin
      level_q <= `EOC_LVL_F;
    end else begin
      level_q <= level_d;
    end
  end

endmodule // eoc_strap_decode

// file: eoc_output_control.v
// eoc_output_control.v: digital control of a one-input, two-output
// cable equalizer: strap defaults, register overrides, mute on length.
// assumes: serial framing is decoded elsewhere into the register port;
// comparator, length and loop inputs are synchronous to clk;
// register strobes are one cycle wide and reads have no side effect.
`timescale 1ns/10ps
`include "eoc_consts.vh"

module eoc_output_control #(
  parameter NUM_OUT = 2
) (
  input  wire       clk,
  input  wire       rst_b,
  // strap comparators, thermometer coded
  input  wire [2:0] path_strap_cmp,
  input  wire [2:0] func_strap_cmp,
  input  wire [2:0] swing_emphasis_strap_cmp,
  // register port
  input  wire [7:0] reg_addr,
  input  wire [7:0] reg_wdata,
  input  wire       reg_wr,
  input  wire       reg_rd,
  output reg  [7:0] reg_rdata,
  // analog loop results
  input  wire [5:0] cable_len_est,
  input  wire [3:0] loop_boost,
  input  wire [3:0] loop_offset,
  // controls to the datapath
  output reg        first_output_en,
  output reg        second_output_en,
  output reg        eq_bypass,
  output reg        splitter_mode,
  output reg        output_mute,
  output reg  [2:0] first_output_swing,
  output reg  [2:0] first_deemphasis_level,
  output reg  [2:0] second_output_swing,
  output reg  [2:0] second_deemphasis_level,
  output reg  [3:0] eq_boost,
  output reg  [3:0] dc_offset_comp
);

  wire [1:0] path_lvl;
  wire [1:0] func_lvl;
  wire [1:0] swing_lvl;

  // strap pins, one decoder each
  eoc_strap_decode u_path_strap (
    .clk       (clk),
    .rst_b     (rst_b),
    .cmp_above (path_strap_cmp),
    .level_q   (path_lvl)
  );

  eoc_strap_decode u_func_strap (
    .clk       (clk),
    .rst_b     (rst_b),
    .cmp_above (func_strap_cmp),
    .level_q   (func_lvl)
  );

  eoc_strap_decode u_swing_strap (
    .clk       (clk),
    .rst_b     (rst_b),
    .cmp_above (swing_emphasis_strap_cmp),
    .level_q   (swing_lvl)
  );

  // register state
  // overrides and codes hold one slice per output, output 0 lowest
  reg [5:0] mute_thr_q;
  reg [5:0] cable_len_q;
  reg [4:0] path_ctrl_q;
  reg [NUM_OUT-1:0]  swing_ovr_q;
  reg [NUM_OUT*3-1:0] swing_code_q;
  reg [NUM_OUT-1:0]  emph_ovr_q;
  reg [NUM_OUT*3-1:0] emph_code_q;

  // per-output register offsets, swing at even, emphasis at odd
  wire [7:0] swing_addr [0:1];
  wire [7:0] emph_addr  [0:1];
  assign swing_addr[0] = `EOC_ADDR_FIRST_OUTPUT_SWING;
  assign swing_addr[1] = `EOC_ADDR_SECOND_OUTPUT_SWING;
  assign emph_addr[0]  = `EOC_ADDR_FIRST_OUTPUT_EMPH;
  assign emph_addr[1]  = `EOC_ADDR_SECOND_OUTPUT_EMPH;

  // common strap code for swing and emphasis alike
  reg [2:0] strap_code;
  always @* begin
    case (swing_lvl)
      `EOC_LVL_H: strap_code = `EOC_CODE_FOR_H;
      `EOC_LVL_F: strap_code = `EOC_CODE_FOR_F;
      `EOC_LVL_R: strap_code = `EOC_CODE_FOR_R;
      `EOC_LVL_L: strap_code = `EOC_CODE_FOR_L;
      // two-bit level leaves no spare code; float is the safe pick
      default:    strap_code = `EOC_CODE_FOR_F;
    endcase
  end

  // per-output override storage and selection
  wire [NUM_OUT*3-1:0] swing_sel;
  wire [NUM_OUT*3-1:0] emph_sel;

  genvar gi;
  generate
    for (gi = 0; gi < NUM_OUT; gi = gi + 1) begin : g_out
      // one decode per output; the offset tables hold outputs 0 and 1 only
      wire swing_hit = reg_wr && (reg_addr == swing_addr[gi]);
      wire emph_hit  = reg_wr && (reg_addr == emph_addr[gi]);

      always @(posedge clk) begin
        if (!rst_b) begin
          swing_ovr_q[gi]         <= 1'b0;
          swing_code_q[gi*3 +: 3] <= `EOC_RST_CODE;
          emph_ovr_q[gi]          <= 1'b0;
          emph_code_q[gi*3 +: 3]  <= `EOC_RST_CODE;
        end else begin
          if (swing_hit) begin
            swing_ovr_q[gi] <= reg_wdata[`EOC_SWING_OVR_BIT];
            // full three-bit range, codes up to 7
            swing_code_q[gi*3 +: 3] <= reg_wdata[2:0];
          end
          if (emph_hit) begin
            emph_ovr_q[gi] <= reg_wdata[`EOC_EMPH_OVR_BIT];
            emph_code_q[gi*3 +: 3] <= reg_wdata[2:0];
          end
        end
      end

      // code field is kept but unused while its override is clear
      assign swing_sel[gi*3 +: 3] = swing_ovr_q[gi] ?
        swing_code_q[gi*3 +: 3] : strap_code;
      assign emph_sel[gi*3 +: 3] = emph_ovr_q[gi] ?
        emph_code_q[gi*3 +: 3] : strap_code;
    end
  endgenerate

  // write decode for the shared registers; 0x25 has no hit, so writes
  // to the read-only length are dropped
  wire wr_mute_thr  = reg_wr && (reg_addr == `EOC_ADDR_MUTE_THR);
  wire wr_path_ctrl = reg_wr && (reg_addr == `EOC_ADDR_PATH_CTRL);

  // shared registers
  always @(posedge clk) begin
    if (!rst_b) begin
      mute_thr_q  <= `EOC_RST_MUTE_THR;
      path_ctrl_q <= `EOC_RST_PATH_CTRL;
    end else begin
      if (wr_mute_thr) begin
        mute_thr_q <= reg_wdata[`EOC_LEN_MSB:0];
      end
      if (wr_path_ctrl) begin
        // splitter mode has no strap, this write is its only way in
        path_ctrl_q <= reg_wdata[4:0];
      end
    end
  end

  // path control fields
  wire path_ovr    = path_ctrl_q[`EOC_PATH_OVR_BIT];
  wire path_dual   = path_ctrl_q[`EOC_PATH_DUAL_BIT];
  wire func_ovr    = path_ctrl_q[`EOC_FUNC_OVR_BIT];
  wire func_bypass = path_ctrl_q[`EOC_FUNC_BYPASS_BIT];
  wire split_en    = path_ctrl_q[`EOC_SPLIT_EN_BIT];

  // cable length estimate, clamped to the top of the reading scale;
  // a wider analog swing must not read past 55
  wire [5:0] len_clamped = (cable_len_est > `EOC_LEN_MAX) ?
    `EOC_LEN_MAX : cable_len_est;

  always @(posedge clk) begin
    if (!rst_b) begin
      cable_len_q <= 6'h00;
    end else begin
      cable_len_q <= len_clamped;
    end
  end

  // register read, one cycle after the strobe; unmapped reads zero
  reg [7:0] rdata_d;
  always @* begin
    rdata_d = 8'h00;
    case (reg_addr)
      `EOC_ADDR_MUTE_THR: rdata_d = {2'h0, mute_thr_q};
      `EOC_ADDR_CABLE_LEN: rdata_d = {2'h0, cable_len_q};
      `EOC_ADDR_FIRST_OUTPUT_SWING:
        rdata_d = {2'h0, swing_ovr_q[0], 2'h0, swing_code_q[2:0]};
      `EOC_ADDR_FIRST_OUTPUT_EMPH:
        rdata_d = {1'h0, emph_ovr_q[0], 3'h0, emph_code_q[2:0]};
      `EOC_ADDR_SECOND_OUTPUT_SWING:
        rdata_d = {2'h0, swing_ovr_q[1], 2'h0, swing_code_q[5:3]};
      `EOC_ADDR_SECOND_OUTPUT_EMPH:
        rdata_d = {1'h0, emph_ovr_q[1], 3'h0, emph_code_q[5:3]};
      `EOC_ADDR_PATH_CTRL: rdata_d = {3'h0, path_ctrl_q};
      default: rdata_d = 8'h00;
    endcase
  end

  // holds between reads, so a slow host may sample it late
  always @(posedge clk) begin
    if (!rst_b) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd) begin
      reg_rdata <= rdata_d;
    end
  end

  // routing, strap default unless overridden
  reg dual_d;
  always @* begin
    if (path_ovr) begin
      dual_d = path_dual;
    end else if (path_lvl == `EOC_LVL_F) begin
      dual_d = 1'b0;
    end else begin
      // reserved low levels fall back to the fan-out routing
      dual_d = 1'b1;
    end
  end

  // output function, strap default unless overridden
  reg bypass_d;
  always @* begin
    if (func_ovr) begin
      bypass_d = func_bypass;
    end else if (func_lvl == `EOC_LVL_H) begin
      bypass_d = 1'b1;
    end else begin
      // float and reserved levels give equalized data
      bypass_d = 1'b0;
    end
  end

  // length beyond threshold silences both drivers, strict compare
  // not gated by bypass: a raw path past the threshold is silenced too
  wire mute_d = (cable_len_q > mute_thr_q);

  // routing, function and mute controls
  always @(posedge clk) begin
    if (!rst_b) begin
      first_output_en  <= 1'b1;
      second_output_en <= 1'b0;
      eq_bypass        <= 1'b0;
      splitter_mode    <= 1'b0;
      output_mute      <= 1'b0;
    end else begin
      // no control turns the first driver off
      first_output_en  <= 1'b1;
      second_output_en <= dual_d;
      eq_bypass        <= bypass_d;
      splitter_mode    <= split_en;
      output_mute      <= mute_d;
    end
  end

  // driver swing and emphasis codes, float strap view in reset
  always @(posedge clk) begin
    if (!rst_b) begin
      first_output_swing      <= `EOC_CODE_FOR_F;
      first_deemphasis_level  <= `EOC_CODE_FOR_F;
      second_output_swing     <= `EOC_CODE_FOR_F;
      second_deemphasis_level <= `EOC_CODE_FOR_F;
    end else begin
      first_output_swing      <= swing_sel[2:0];
      first_deemphasis_level  <= emph_sel[2:0];
      second_output_swing     <= swing_sel[5:3];
      second_deemphasis_level <= emph_sel[5:3];
    end
  end

  // loops run on their own; no register touches these
  always @(posedge clk) begin
    if (!rst_b) begin
      eq_boost       <= 4'h0;
      dc_offset_comp <= 4'h0;
    end else begin
      eq_boost       <= loop_boost;
      dc_offset_comp <= loop_offset;
    end
  end

endmodule // eoc_output_control

// file: eoc_output_control_asserts.sv
// eoc_output_control_asserts.sv: port checker for the output control
// assumes: bound to eoc_output_control, one clock, sync reset rst_b
`timescale 1ns/10ps
module eoc_oc_asserts (
  input wire       clk,
  input wire       rst_b,
  input wire [7:0] reg_addr,
  input wire [7:0] reg_wdata,
  input wire       reg_wr,
  input wire       reg_rd,
  input wire [7:0] reg_rdata,
  input wire [5:0] cable_len_est,
  input wire [3:0] loop_boost,
  input wire [3:0] loop_offset,
  input wire       first_output_en,
  input wire       splitter_mode,
  input wire       output_mute,
  input wire [2:0] first_output_swing,
  input wire [2:0] second_deemphasis_level,
  input wire [3:0] eq_boost,
  input wire [3:0] dc_offset_comp
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_b);

  sequence s_wr(logic [7:0] a);
    reg_wr && reg_addr == a;
  endsequence

  a_first_on: assert property (first_output_en)
    else $error("first output disabled");
  a_swing_ovr: assert property (s_wr(8'h30) ##0 reg_wdata[5]
    |-> ##2 first_output_swing == $past(reg_wdata[2:0], 2))
    else $error("swing override not applied");
  a_emph_ovr: assert property (s_wr(8'h33) ##0 reg_wdata[6]
    |-> ##2 second_deemphasis_level == $past(reg_wdata[2:0], 2))
    else $error("emphasis override not applied");
  a_split_reg: assert property (s_wr(8'h34)
    |-> ##2 splitter_mode == $past(reg_wdata[4], 2))
    else $error("splitter mode not from register");
  // only from an edge out of reset: the reset edge clears the copy
  a_boost_follow: assert property (rst_b
    |=> eq_boost == $past(loop_boost))
    else $error("boost not following loop");
  a_offset_follow: assert property (rst_b
    |=> dc_offset_comp == $past(loop_offset))
    else $error("offset not following loop");
  a_rdata_hold: assert property (!reg_rd |=> $stable(reg_rdata))
    else $error("read data changed without read");
  a_len_range: assert property (reg_rd && reg_addr == 8'h25
    |=> reg_rdata <= 8'h37)
    else $error("length reading out of range");
  a_mute_zero: assert property (cable_len_est == 6'h0
    |-> ##2 !output_mute)
    else $error("muted at zero length");
endmodule // eoc_oc_asserts

bind eoc_output_control eoc_oc_asserts eoc_oc_asserts_i (
  .clk(clk), .rst_b(rst_b), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
  .cable_len_est(cable_len_est), .loop_boost(loop_boost),
  .loop_offset(loop_offset), .first_output_en(first_output_en),
  .splitter_mode(splitter_mode), .output_mute(output_mute),
  .first_output_swing(first_output_swing),
  .second_deemphasis_level(second_deemphasis_level),
  .eq_boost(eq_boost), .dc_offset_comp(dc_offset_comp));

// file: eoc_cable_model.sv
// eoc_cable_model.sv: far side, a driven cable of settable length
// assumes: estimate and loop results are synchronous to clk
`timescale 1ns/10ps
module eoc_cable_model (
  input  wire        clk,
  input  wire  [5:0] cable_m,
  output logic [5:0] cable_len_est,
  output logic [3:0] loop_boost,
  output logic [3:0] loop_offset
);
  initial cable_len_est = 6'h00;
  // adaptation slews one step a clock, so the estimate lags the cable
  always @(posedge clk) begin
    if (cable_len_est < cable_m)
      cable_len_est <= cable_len_est + 6'h01;
    else if (cable_len_est > cable_m)
      cable_len_est <= cable_len_est - 6'h01;
  end
  assign loop_boost = cable_len_est[5:2];
  assign loop_offset = cable_len_est[3:0] ^ 4'ha;
endmodule // eoc_cable_model

// file: eoc_output_control_tb_top.sv
// eoc_output_control_tb_top.sv: register and strap tests of the block
// assumes: 40 MHz clock, register port strobes one cycle wide
`timescale 1ns/10ps
module eoc_output_control_tb_top;
  logic        clk, rst_b, reg_wr, reg_rd;
  logic [2:0]  p_cmp, f_cmp, s_cmp, sw0, de0, sw1, de1;
  logic [7:0]  reg_addr, reg_wdata, reg_rdata;
  logic [5:0]  cable_m, len_est;
  logic [3:0]  boost, offs, eq_boost, dc_offset_comp;
  logic        o0_en, o1_en, byp, split, mute;
  int          error_cnt, n_checks, l, i;
  // index 0 low, 1 resistor-low, 2 float, 3 high
  localparam logic [2:0] code_tab [4] = '{3'h5, 3'h3, 3'h2, 3'h0};

  eoc_output_control #(.NUM_OUT(2)) eoc_output_control_i (
    .clk(clk), .rst_b(rst_b), .path_strap_cmp(p_cmp),
    .func_strap_cmp(f_cmp), .swing_emphasis_strap_cmp(s_cmp),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .cable_len_est(len_est),
    .loop_boost(boost), .loop_offset(offs), .first_output_en(o0_en),
    .second_output_en(o1_en), .eq_bypass(byp), .splitter_mode(split),
    .output_mute(mute), .first_output_swing(sw0),
    .first_deemphasis_level(de0), .second_output_swing(sw1),
    .second_deemphasis_level(de1), .eq_boost(eq_boost),
    .dc_offset_comp(dc_offset_comp));
  eoc_cable_model eoc_cable_model_i (.clk(clk), .cable_m(cable_m),
    .cable_len_est(len_est), .loop_boost(boost), .loop_offset(offs));

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  function automatic logic [2:0] cmp_of(int lv);
    return 3'h7 >> (3 - lv);
  endfunction

  task final_report;
    $display("checks %0d errors %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  task chk(input logic [15:0] got, input logic [15:0] exp);
    n_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("[ERR] t=%0t got %h exp %h", $time, got, exp);
    end
  endtask

  task wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask

  task rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 chk({8'h0, reg_rdata}, {8'h0, exp});
  endtask

  // outputs follow a change two edges later; three leaves margin
  task settle;
    repeat (3) @(posedge clk);
    #1;
  endtask

  task set_len(input logic [5:0] m);
    @(posedge clk) cable_m <= m;
    for (i = 0; i < 100 && len_est !== m; i++)
      @(posedge clk);
    if (len_est !== m) begin
      chk({10'h0, len_est}, {10'h0, m});
      final_report;
    end
    settle;
  endtask

  initial begin
    #500000;
    error_cnt++;
    final_report;
  end

  initial begin
    error_cnt = 0;
    n_checks = 0;
    rst_b = 1'b0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    p_cmp = 3'h7;
    f_cmp = 3'h3;
    s_cmp = 3'h3;
    cable_m = 6'h00;
    repeat (2) @(posedge clk);
    rst_b <= 1'b1;
    rd(8'h03, 8'h37);
    rd(8'h30, 8'h00);
    for (l = 0; l < 4; l++) begin
      @(posedge clk) s_cmp <= cmp_of(l);
      settle;
      chk({4'h0, sw0, de0, sw1, de1}, {4'h0, {4{code_tab[l]}}});
    end
    for (l = 0; l < 4; l++) begin
      @(posedge clk) p_cmp <= cmp_of(l);
      f_cmp <= cmp_of(l);
      settle;
      chk({o0_en, o1_en, byp, split},
          {1'b1, l != 2, l == 3, 1'b0});
    end
    // float swing strap and equalized function under the overrides
    @(posedge clk) f_cmp <= 3'h3;
    s_cmp <= 3'h3;
    wr(8'h30, 8'h07);
    settle;
    chk({13'h0, sw0}, 16'h2);
    wr(8'h30, 8'hff);
    settle;
    chk({10'h0, sw0, sw1}, {10'h0, 3'h7, 3'h2});
    rd(8'h30, 8'h27);
    wr(8'h33, 8'h46);
    settle;
    chk({10'h0, de0, de1}, {10'h0, 3'h2, 3'h6});
    rd(8'h33, 8'h46);
    wr(8'h34, 8'h01);
    settle;
    chk({15'h0, o1_en}, 16'h0);
    wr(8'h34, 8'h1e);
    settle;
    chk({13'h0, o1_en, byp, split}, 16'h7);
    set_len(6'h1e);
    rd(8'h25, 8'h1e);
    wr(8'h03, reg_rdata);
    settle;
    chk({15'h0, mute}, 16'h0);
    set_len(6'h1f);
    chk({7'h0, mute, eq_boost, dc_offset_comp}, 16'h175);
    wr(8'h25, 8'h00);
    set_len(6'h3f);
    chk({15'h0, mute}, 16'h1);
    rd(8'h25, 8'h37);
    rd(8'h40, 8'h00);
    @(posedge clk) rst_b <= 1'b0;
    repeat (2) @(posedge clk);
    rst_b <= 1'b1;
    rd(8'h03, 8'h37);
    settle;
    chk({15'h0, mute}, 16'h0);
    final_report;
  end
endmodule // eoc_output_control_tb_top
